// ---- hdl/pbs_burst_mem.v ----
// Byte-lane-writable storage array with registered read port.
`timescale 1ns/1ps
`default_nettype none

module pbs_burst_mem #(
    parameter ADDR_W = 17,
    parameter LANES  = 4,
    parameter LANE_W = 9
) (
    input  wire                    i_clk,
    input  wire                    i_wr_en,
    input  wire [LANES-1:0]        i_wr_lane,
    input  wire [ADDR_W-1:0]       i_wr_addr,
    input  wire [LANES*LANE_W-1:0] i_wr_data,
    input  wire                    i_rd_en,
    input  wire [ADDR_W-1:0]       i_rd_addr,
    output wire [LANES*LANE_W-1:0] o_rd_data
);

    // ----------------------------------------
    // Storage, one array per byte lane
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < LANES; g = g + 1) begin : lane
            reg [LANE_W-1:0] mem [0:(1<<ADDR_W)-1]; // Lane contents, no reset: data survives.
            reg [LANE_W-1:0] rd_reg;                // Registered read lane.

            // Only selected lanes update; the rest keep their contents.
            always @(posedge i_clk) begin
                if (i_wr_en && i_wr_lane[g]) begin
                    mem[i_wr_addr] <= i_wr_data[g*LANE_W +: LANE_W];
                end
                if (i_rd_en) begin
                    rd_reg <= mem[i_rd_addr];
                end
            end

            assign o_rd_data[g*LANE_W +: LANE_W] = rd_reg;
        end
    endgenerate

endmodule
`default_nettype wire

// ---- hdl/pbs_defines.vh ----
// Constants of the pipelined burst memory port.
`ifndef PBS_DEFINES_VH
`define PBS_DEFINES_VH

// ----------------------------------------
// Geometry
// ----------------------------------------
`define PBS_ADDR_W      17
`define PBS_LANES       4
`define PBS_LANE_W      8
`define PBS_BURST_W     2

// ----------------------------------------
// Burst order strap values
// ----------------------------------------
`define PBS_ORDER_LINEAR 1'b0
`define PBS_ORDER_INTLV  1'b1

// ----------------------------------------
// Sleep timing
// ----------------------------------------
`define PBS_SLEEP_CYCLES 2'h2

// ----------------------------------------
// Control states of the sleep tracker
// ----------------------------------------
`define PBS_SLP_AWAKE    2'h0
`define PBS_SLP_ENTER    2'h1
`define PBS_SLP_ASLEEP   2'h2
`define PBS_SLP_EXIT     2'h3

`endif

// ---- hdl/pbs_port.v ----
// Synchronous port logic of a pipelined burst static memory with common I/O.
//
// Overview of operation
// - High clock qualifier freezes access and output data state; sleep tracker and input synchronisers still run.
// - Inputs captured, read data registered, rising edge.
// - Read starts: qualified, selected, write high, load.
// - Read data driven after second edge, gate low.
// - New operation accepted right after a read.
// - Deselect tristates outputs after the second edge.
// - Burst counter gives four accesses per address.
// - Order strap: low linear, high interleaved.
// - Counter alters two low bits, wraps.
// - Advance steps counter, ignores selects and write.
// - Access type latched for whole burst.
// - Write starts: qualified, selected, write low.
// - Outputs tristate on second edge after write address.
// - Write data latched second edge after address.
// - Only selected byte lanes are written.
// - Sleep input idles device, data kept.
// - Interleaved order XORs first with beat count.
// - Linear order adds beat count modulo four.
// - Outputs tristate first clock after deselect exit.
// - Sleep entry and exit take two cycles.
`timescale 1ns/1ps
`default_nettype none
`include "pbs_defines.vh"

module pbs_port #(
    parameter ADDR_W = `PBS_ADDR_W,
    parameter LANES  = `PBS_LANES
) (
    input  wire                    i_clk,
    input  wire                    i_rst,
    input  wire                    i_clk_qualify_n,
    input  wire                    i_chip_sel_one_n,
    input  wire                    i_chip_sel_two,
    input  wire                    i_chip_sel_three_n,
    input  wire                    i_load_or_advance,
    input  wire                    i_write_n,
    input  wire [LANES-1:0]        i_byte_lane_write_n,
    input  wire [ADDR_W-1:0]       i_addr_in,
    input  wire                    i_out_gate_n,
    input  wire                    i_burst_order,
    input  wire                    i_sleep_request,
    input  wire [LANES*8-1:0]      i_data_bus,
    input  wire [LANES-1:0]        i_parity_bus,
    output reg  [LANES*8-1:0]      o_data_bus,
    output reg  [LANES-1:0]        o_parity_bus,
    output reg  [LANES*9-1:0]      o_data_oe,
    output reg                     o_sleeping
);

    // ----------------------------------------
    // Local widths
    // ----------------------------------------
    localparam BW    = `PBS_BURST_W;    // Burst counter width.
    localparam WORD  = LANES * 9;       // Data plus parity per word.

    // ----------------------------------------
    // Burst address function
    // ----------------------------------------
    // Next low address bits for a burst beat, given the starting bits and beat.
    function [BW-1:0] burst_addr;
        input          order;
        input [BW-1:0] first;
        input [BW-1:0] beat;
        begin
            if (order == `PBS_ORDER_INTLV) begin
                burst_addr = first ^ beat;
            end else begin
                burst_addr = first + beat;
            end
        end
    endfunction

    // ----------------------------------------
    // Sleep input synchroniser
    // ----------------------------------------
    wire sleep_sync;                    // Sleep request after two flip-flops.

    pbs_sync2 #(
        .WIDTH (1)
    ) u_sleep_sync (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_async (i_sleep_request),
        .o_sync  (sleep_sync)
    );

    // ----------------------------------------
    // Input capture registers
    // ----------------------------------------
    // The gate is asynchronous on the pin but the outputs are
    // registered, so it is synchronised like the strap and sleep inputs.
    reg              gate_meta_reg;    // First stage for the output gate.
    reg              gate_n_reg;       // Synchronised output gate, active low.
    reg              order_meta_reg;   // First stage for the order strap.
    reg              order_reg;        // Synchronised order strap.

    // Two-stage capture of the gate and strap levels.
    always @(posedge i_clk) begin
        if (i_rst) begin
            gate_meta_reg  <= 1'b1;
            gate_n_reg     <= 1'b1;
            order_meta_reg <= 1'b0;
            order_reg      <= 1'b0;
        end else begin
            gate_meta_reg  <= i_out_gate_n;
            gate_n_reg     <= gate_meta_reg;
            order_meta_reg <= i_burst_order;
            order_reg      <= order_meta_reg;
        end
    end

    // ----------------------------------------
    // Sleep tracker
    // ----------------------------------------
    reg [1:0] slp_state_reg;            // Sleep state.
    reg [1:0] slp_state_next;
    reg [1:0] slp_cnt_reg;              // Cycles spent in a transition.
    reg [1:0] slp_cnt_next;
    wire      awake;                    // Port may run operations.

    // Entry and exit each run a two-cycle transition before settling.
    always @* begin
        slp_state_next = slp_state_reg;
        slp_cnt_next   = slp_cnt_reg;
        case (slp_state_reg)
            `PBS_SLP_AWAKE: begin
                if (sleep_sync) begin
                    slp_state_next = `PBS_SLP_ENTER;
                    slp_cnt_next   = 2'h1;
                end
            end
            `PBS_SLP_ENTER: begin
                if (slp_cnt_reg >= `PBS_SLEEP_CYCLES) begin
                    slp_state_next = `PBS_SLP_ASLEEP;
                end else begin
                    slp_cnt_next   = slp_cnt_reg + 2'h1;
                end
            end
            `PBS_SLP_ASLEEP: begin
                if (!sleep_sync) begin
                    slp_state_next = `PBS_SLP_EXIT;
                    slp_cnt_next   = 2'h1;
                end
            end
            `PBS_SLP_EXIT: begin
                if (slp_cnt_reg >= `PBS_SLEEP_CYCLES) begin
                    slp_state_next = `PBS_SLP_AWAKE;
                end else begin
                    slp_cnt_next   = slp_cnt_reg + 2'h1;
                end
            end
            default: begin
                slp_state_next = `PBS_SLP_AWAKE;
                slp_cnt_next   = 2'h0;
            end
        endcase
    end

    // Sleep ignores the clock qualifier.
    always @(posedge i_clk) begin
        if (i_rst) begin
            slp_state_reg <= `PBS_SLP_AWAKE;
            slp_cnt_reg   <= 2'h0;
        end else begin
            slp_state_reg <= slp_state_next;
            slp_cnt_reg   <= slp_cnt_next;
        end
    end

    assign awake = (slp_state_reg == `PBS_SLP_AWAKE) && !sleep_sync;

    // ----------------------------------------
    // Operation decode
    // ----------------------------------------
    wire edge_ok;                       // Edge is qualified and device awake.
    wire selected;                      // All three chip selects active.
    wire load_cmd;                      // Load cycle this edge: new address if selected, else deselect.
    wire adv_cmd;                       // Burst advance this edge.

    assign edge_ok  = !i_clk_qualify_n && awake;
    assign selected = !i_chip_sel_one_n && i_chip_sel_two && !i_chip_sel_three_n;
    assign load_cmd = edge_ok && !i_load_or_advance;
    assign adv_cmd  = edge_ok && i_load_or_advance;

    // ----------------------------------------
    // Address and burst state (access cycle)
    // ----------------------------------------
    reg [ADDR_W-1:0] base_reg;          // Address loaded at burst start.
    reg [BW-1:0]     beat_reg;          // Beats taken since the load.
    reg              active_reg;        // A burst is in progress.
    reg              is_write_reg;      // Burst type, one for write.

    reg              s1_valid_reg;      // An access happens this cycle.
    reg              s1_write_reg;      // That access is a write.
    reg [ADDR_W-1:0] s1_addr_reg;       // Its full address.
    reg [LANES-1:0]  s1_lanes_reg;      // Its byte lanes to write.
    reg              s1_fresh_reg;      // Access follows a deselect.

    wire [BW-1:0]    step_beat;
    assign step_beat = beat_reg + 2'h1;

    // Capture each qualified edge; a stalled edge holds everything.
    always @(posedge i_clk) begin
        if (i_rst) begin
            base_reg     <= {ADDR_W{1'b0}};
            beat_reg     <= 2'h0;
            active_reg   <= 1'b0;
            is_write_reg <= 1'b0;
            s1_valid_reg <= 1'b0;
            s1_write_reg <= 1'b0;
            s1_addr_reg  <= {ADDR_W{1'b0}};
            s1_lanes_reg <= {LANES{1'b0}};
            s1_fresh_reg <= 1'b0;
        end else if (!awake) begin
            // Sleep drops pending accesses.
            active_reg   <= 1'b0;
            s1_valid_reg <= 1'b0;
            s1_write_reg <= 1'b0;
        end else if (load_cmd) begin
            s1_fresh_reg <= !active_reg;
            if (selected) begin
                base_reg     <= i_addr_in;
                beat_reg     <= 2'h0;
                active_reg   <= 1'b1;
                is_write_reg <= !i_write_n;
                s1_valid_reg <= 1'b1;
                s1_write_reg <= !i_write_n;
                s1_addr_reg  <= i_addr_in;
                s1_lanes_reg <= ~i_byte_lane_write_n;
            end else begin
                active_reg   <= 1'b0;
                s1_valid_reg <= 1'b0;
                s1_write_reg <= 1'b0;
            end
        end else if (adv_cmd) begin
            s1_fresh_reg <= 1'b0;
            if (active_reg) begin
                // Selects and write line are ignored while advancing.
                beat_reg     <= step_beat;
                s1_valid_reg <= 1'b1;
                s1_write_reg <= is_write_reg;
                s1_addr_reg  <= {base_reg[ADDR_W-1:BW],
                                 burst_addr(order_reg, base_reg[BW-1:0], step_beat)};
                s1_lanes_reg <= ~i_byte_lane_write_n;
            end else begin
                s1_valid_reg <= 1'b0;
                s1_write_reg <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Data stage (read out or write data)
    // ----------------------------------------
    reg              rd_drive_reg;      // Read data is due on the bus.
    reg              wr_pend_reg;       // Write data arrives at next edge.
    reg [ADDR_W-1:0] wr_addr_reg;       // Address of that write.
    reg [LANES-1:0]  wr_lanes_reg;      // Lanes of that write.
    reg              rd_fresh_reg;      // Read follows a deselect.

    // Writes carry their address to the data edge.
    always @(posedge i_clk) begin
        if (i_rst) begin
            rd_drive_reg <= 1'b0;
            wr_pend_reg  <= 1'b0;
            wr_addr_reg  <= {ADDR_W{1'b0}};
            wr_lanes_reg <= {LANES{1'b0}};
            rd_fresh_reg <= 1'b0;
        end else if (!awake) begin
            rd_drive_reg <= 1'b0;
            wr_pend_reg  <= 1'b0;
        end else if (edge_ok) begin
            rd_drive_reg <= s1_valid_reg && !s1_write_reg;
            wr_pend_reg  <= s1_valid_reg && s1_write_reg;
            wr_addr_reg  <= s1_addr_reg;
            wr_lanes_reg <= s1_lanes_reg;
            rd_fresh_reg <= s1_fresh_reg;
        end
    end

    // ----------------------------------------
    // Storage array
    // ----------------------------------------
    wire [WORD-1:0] wr_word;            // Data plus parity, lane by lane.
    wire [WORD-1:0] rd_word;            // Registered word from storage.
    wire            do_write;           // Write completes at this edge.
    wire            do_read;            // Read address presented this edge.

    genvar g;
    generate
        for (g = 0; g < LANES; g = g + 1) begin : pack
            // Parity sits above its lane and shares its select.
            assign wr_word[g*9 +: 9] = {i_parity_bus[g], i_data_bus[g*8 +: 8]};
        end
    endgenerate

    assign do_write = edge_ok && wr_pend_reg;
    assign do_read  = edge_ok && s1_valid_reg && !s1_write_reg;

    pbs_burst_mem #(
        .ADDR_W (ADDR_W),
        .LANES  (LANES),
        .LANE_W (9)
    ) u_mem (
        .i_clk     (i_clk),
        .i_wr_en   (do_write),
        .i_wr_lane (wr_lanes_reg),
        .i_wr_addr (wr_addr_reg),
        .i_wr_data (wr_word),
        .i_rd_en   (do_read),
        .i_rd_addr (s1_addr_reg),
        .o_rd_data (rd_word)
    );

    // ----------------------------------------
    // Output registers and drivers
    // ----------------------------------------
    wire drive_now;                     // Drivers on in the coming cycle.
    reg  [WORD-1:0] out_word;           // Read word split back to pins.
    integer k;

    // Drive only with the gate low, never for write data
    // or the first beat out of a deselect.
    assign drive_now = rd_drive_reg && !gate_n_reg && !rd_fresh_reg;

    always @* begin
        out_word = rd_word;
    end

    // Data holds on ignored edges so a stall freezes the bus.
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_data_bus   <= {(LANES*8){1'b0}};
            o_parity_bus <= {LANES{1'b0}};
            o_data_oe    <= {WORD{1'b0}};
            o_sleeping   <= 1'b0;
        end else begin
            if (edge_ok) begin
                for (k = 0; k < LANES; k = k + 1) begin
                    o_data_bus[k*8 +: 8] <= out_word[k*9 +: 8];
                    o_parity_bus[k]      <= out_word[k*9 + 8];
                end
            end
            o_data_oe  <= {WORD{drive_now}};
            o_sleeping <= (slp_state_reg == `PBS_SLP_ASLEEP);
        end
    end

endmodule
`default_nettype wire

// ---- hdl/pbs_sync2.v ----
// Two-flop synchroniser for an asynchronous level.
`timescale 1ns/1ps
`default_nettype none

module pbs_sync2 #(
    parameter WIDTH = 1
) (
    input  wire             i_clk,
    input  wire             i_rst,
    input  wire [WIDTH-1:0] i_async,
    output wire [WIDTH-1:0] o_sync
);

    // ----------------------------------------
    // Synchroniser stages
    // ----------------------------------------
    reg [WIDTH-1:0] meta_reg;   // First stage.
    reg [WIDTH-1:0] sync_reg;   // Second stage.

    // Both stages clear on reset.
    always @(posedge i_clk) begin
        if (i_rst) begin
            meta_reg <= {WIDTH{1'b0}};
            sync_reg <= {WIDTH{1'b0}};
        end else begin
            meta_reg <= i_async;
            sync_reg <= meta_reg;
        end
    end

    assign o_sync = sync_reg;

endmodule
`default_nettype wire

// ---- sim/pbs_host.sv ----
// Host controller model driving the memory port's controls and write data.
`timescale 1ns/1ps
`default_nettype none
module pbs_host (
    input  wire logic        i_clk,
    output var  logic        o_qn,     // Clock qualifier, active low.
    output var  logic [2:0]  o_sel,    // Chip selects {one_n, two, three_n}.
    output var  logic        o_adv,    // Load (0) or advance (1).
    output var  logic        o_wr_n,   // Write select, low for a write.
    output var  logic [3:0]  o_lane_n, // Byte lane write selects.
    output var  logic [16:0] o_addr,   // Access address.
    output var  logic        o_gate_n, // Output gate.
    output var  logic        o_order,  // Burst order strap.
    output var  logic        o_sleep,  // Sleep request.
    output var  logic [35:0] o_dq      // Write word {parity, data}.
);
    // ----------------------------------------
    // Write data pipe
    // ----------------------------------------
    logic [36:0] pend0; // Newest word with its valid flag.
    logic [36:0] pend1; // Word one taken rise older.
    logic [36:0] cur;   // Word on the bus now.
    initial begin
        {o_qn, o_sel, o_adv, o_wr_n, o_lane_n, o_addr} = {1'b0, 3'b110, 1'b0, 1'b1, 4'hf, 17'h0};
        {o_gate_n, o_order, o_sleep, o_dq, pend0, pend1, cur} = '0; // Gate kept low for reads.
    end
    // One bus cycle, driven at the falling edge.
    task automatic step(input logic qn, input logic [2:0] sel, input logic adv, input logic wn,
                        input logic [3:0] ln, input logic [16:0] a, input logic [36:0] wd);
        @(negedge i_clk);
        if (!o_qn) begin // Last rise was qualified.
            cur = pend1;
            pend1 = pend0;
        end
        pend0 = wd;
        // Word due two rises on; else toggle.
        o_dq = cur[36] ? cur[35:0] : ~o_dq;
        o_qn = qn;
        o_sel = sel; // Selected only as 3'b010.
        o_adv = adv; // Loads after a deselect.
        o_wr_n = wn;
        o_lane_n = ln;
        o_addr = a;
    endtask
    // Strap and sleep, changed while no burst is active.
    task automatic mode(input logic ord, input logic slp);
        @(negedge i_clk);
        o_order = ord;
        o_sleep = slp;
    endtask
endmodule
`default_nettype wire

// ---- sim/pbs_port_properties.sv ----
// Concurrent checks on the ports of the pipelined burst memory port.
`timescale 1ns/1ps
`default_nettype none
module pbs_port_properties #(
    parameter ADDR_W = 17,
    parameter LANES  = 4
) (
    input wire logic               i_clk,
    input wire logic               i_rst,
    input wire logic               i_clk_qualify_n,
    input wire logic               i_chip_sel_one_n,
    input wire logic               i_chip_sel_two,
    input wire logic               i_chip_sel_three_n,
    input wire logic               i_load_or_advance,
    input wire logic               i_write_n,
    input wire logic               i_out_gate_n,
    input wire logic               i_sleep_request,
    input wire logic [LANES*8-1:0] o_data_bus,
    input wire logic [LANES-1:0]   o_parity_bus,
    input wire logic [LANES*9-1:0] o_data_oe,
    input wire logic               o_sleeping
);
    // ----------------------------------------
    // Decoded cycle kinds
    // ----------------------------------------
    // Edges near sleep are left out.
    wire sel_on = !i_chip_sel_one_n && i_chip_sel_two && !i_chip_sel_three_n;
    wire awake  = !i_clk_qualify_n && !i_sleep_request && !o_sleeping;
    wire rd_ld  = awake && sel_on && !i_load_or_advance && i_write_n;
    wire wr_ld  = awake && sel_on && !i_load_or_advance && !i_write_n;
    wire dsel   = awake && !sel_on && !i_load_or_advance;
    wire adv    = awake && i_load_or_advance;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence s_rd_head;
        (rd_ld && !i_out_gate_n) ##1 (adv && !i_out_gate_n)[*2] ##1 (awake && !i_out_gate_n);
    endsequence
    sequence s_dsel_run;
        dsel ##1 (!i_clk_qualify_n)[*2];
    endsequence
    property p_stall_hold; i_clk_qualify_n |=> $stable(o_data_bus) && $stable(o_parity_bus); endproperty
    property p_write_quiet; wr_ld ##1 !i_clk_qualify_n |=> o_data_oe == '0; endproperty
    property p_desel_quiet; s_dsel_run |=> o_data_oe == '0; endproperty
    property p_first_mask; dsel ##1 rd_ld ##1 (!i_clk_qualify_n)[*2] |=> o_data_oe == '0; endproperty
    property p_read_drive; s_rd_head |=> o_data_oe == '1; endproperty
    property p_adv_desel; dsel ##1 adv[*3] |=> o_data_oe == '0; endproperty
    property p_sleep_enter; i_sleep_request[*8] |-> o_sleeping; endproperty
    property p_sleep_exit; (!i_sleep_request)[*8] |-> !o_sleeping; endproperty
    property p_sleep_quiet; o_sleeping |-> o_data_oe == '0; endproperty
    a_stall_hold: assert property (p_stall_hold) else $error("moved on stall");
    a_write_quiet: assert property (p_write_quiet) else $error("drove after write");
    a_desel_quiet: assert property (p_desel_quiet) else $error("drove after deselect");
    a_first_mask: assert property (p_first_mask) else $error("first beat driven");
    a_read_drive: assert property (p_read_drive) else $error("beat not driven");
    a_adv_desel: assert property (p_adv_desel) else $error("advance woke port");
    a_sleep_enter: assert property (p_sleep_enter) else $error("sleep not entered");
    a_sleep_exit: assert property (p_sleep_exit) else $error("sleep not left");
    a_sleep_quiet: assert property (p_sleep_quiet) else $error("drove asleep");
endmodule
bind pbs_port pbs_port_properties #(.ADDR_W(ADDR_W), .LANES(LANES)) i_pbs_port_properties (
    .i_clk(i_clk), .i_rst(i_rst), .i_clk_qualify_n(i_clk_qualify_n), .i_chip_sel_one_n(i_chip_sel_one_n),
    .i_chip_sel_two(i_chip_sel_two), .i_chip_sel_three_n(i_chip_sel_three_n), .i_write_n(i_write_n),
    .i_load_or_advance(i_load_or_advance), .i_out_gate_n(i_out_gate_n), .i_sleep_request(i_sleep_request),
    .o_data_bus(o_data_bus), .o_parity_bus(o_parity_bus), .o_data_oe(o_data_oe), .o_sleeping(o_sleeping));
`default_nettype wire

// ---- sim/pbs_port_tb.sv ----
// Self-checking testbench for the pipelined burst memory port.
`timescale 1ns/1ps
`default_nettype none
`define PBS_CHECK(got, exp) begin check_count++; if ((got) !== (exp)) begin mismatches++; \
    $display("unexpected at %0t: got %h, expected %h", $time, (got), (exp)); end end
module pbs_port_tb;
    // ----------------------------------------
    // Clock, wiring and expectations
    // ----------------------------------------
    logic        i_clk = 1'b0;
    logic        i_rst = 1'b1;
    wire         qn, adv, wr_n, gate_n, order, sleep, slp;
    wire  [2:0]  sel;
    wire  [3:0]  lane_n, op;
    wire  [16:0] addr;
    wire  [35:0] dq, oe;
    wire  [31:0] od;
    int          mismatches = 0;
    int          check_count = 0;
    int          cycles = 0;
    int          seq = 0;                // Write pattern count.
    logic        ord_now = 1'b0;         // Burst order now strapped.
    logic [35:0] ref_mem [logic [16:0]]; // Expected words, {parity, data}.
    initial forever #5 i_clk = ~i_clk;
    pbs_host i_pbs_host (.i_clk(i_clk), .o_qn(qn), .o_sel(sel), .o_adv(adv), .o_wr_n(wr_n), .o_lane_n(lane_n),
        .o_addr(addr), .o_gate_n(gate_n), .o_order(order), .o_sleep(sleep), .o_dq(dq));
    pbs_port #(.ADDR_W(17), .LANES(4)) i_pbs_port (.i_clk(i_clk), .i_rst(i_rst), .i_clk_qualify_n(qn),
        .i_chip_sel_one_n(sel[2]), .i_chip_sel_two(sel[1]), .i_chip_sel_three_n(sel[0]), .i_load_or_advance(adv),
        .i_write_n(wr_n), .i_byte_lane_write_n(lane_n), .i_addr_in(addr), .i_out_gate_n(gate_n),
        .i_burst_order(order), .i_sleep_request(sleep), .i_data_bus(dq[31:0]), .i_parity_bus(dq[35:32]),
        .o_data_bus(od), .o_parity_bus(op), .o_data_oe(oe), .o_sleeping(slp));
    // Burst address of beat j; only the two low bits move.
    function automatic logic [16:0] baddr(input logic [16:0] a, input logic [1:0] j);
        return {a[16:2], ord_now ? (a[1:0] ^ j) : (a[1:0] + j)};
    endfunction
    task automatic idle(input int n);
        repeat (n) i_pbs_host.step(1'b0, 3'b110, 1'b0, 1'b1, 4'hf, 17'h0, 37'h0);
    endtask
    task automatic set_order(input logic o);
        ord_now = o;
        i_pbs_host.mode(o, 1'b0);
        idle(3); // The strap passes two flops first.
    endtask
    // Advances flip ignored selects and write select.
    task automatic wr_burst(input logic [16:0] a, input logic [3:0] ln, input int nb);
        logic [35:0] w;
        for (int i = 0; i < nb + 2; i++) begin
            seq++;
            w = {seq[3:0], 32'h9e3779b9 * seq};
            if (i >= nb) begin
                idle(1);
            end else begin
                i_pbs_host.step(1'b0, i == 0 ? 3'b010 : 3'b011, i != 0, i != 0, ln, a, {1'b1, w});
                for (int g = 0; g < 4; g++)
                    if (!ln[g]) begin // Parity follows its lane.
                        ref_mem[baddr(a, 2'(i))][8*g +: 8] = w[8*g +: 8];
                        ref_mem[baddr(a, 2'(i))][32+g] = w[32+g];
                    end
            end
        end
    endtask
    // Four-beat read, optional stall, ended by deselect kind off.
    task automatic rd_burst(input logic [16:0] a, input int st, input logic [2:0] off);
        int k;
        for (int i = 0; i < 8 + st; i++) begin
            k = (st != 0 && i > 0) ? i - 1 : i;
            if (st != 0 && i == 1) i_pbs_host.step(1'b1, 3'b010, 1'b0, 1'b0, 4'h0, 17'h0, 37'h0);
            else i_pbs_host.step(1'b0, k == 0 ? 3'b010 : (k < 4 ? 3'b110 : off), k inside {1, 2, 3}, k == 0,
                                 4'h0, a, 37'h0);
            if (k == 3) `PBS_CHECK(oe, 36'h0)
            if (k == 7) `PBS_CHECK(oe, 36'h0)
            if (k > 3 && k < 7) begin
                `PBS_CHECK(oe, {36{1'b1}})
                `PBS_CHECK({op, od}, ref_mem[baddr(a, 2'(k - 3))])
            end
        end
    endtask
    task automatic adv_idle();
        for (int i = 0; i < 5; i++) begin
            i_pbs_host.step(1'b0, 3'b010, 1'b1, 1'b0, 4'h0, 17'h0, 37'h0);
            `PBS_CHECK(oe, 36'h0)
        end
    endtask
    task automatic sleep_cycle();
        i_pbs_host.mode(ord_now, 1'b1);
        idle(12);
        `PBS_CHECK({slp, oe}, {1'b1, 36'h0})
        i_pbs_host.mode(ord_now, 1'b0);
        idle(12); // Selects stay off through recovery.
        `PBS_CHECK(slp, 1'b0)
    endtask
    task automatic close_out();
        $display("checks %0d, mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Hung run limit, far past the test length.
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 2000) begin
            mismatches++;
            close_out();
        end
    end
    initial begin
        repeat (5) @(posedge i_clk);
        @(negedge i_clk);
        i_rst = 1'b0;
        set_order(1'b0);
        wr_burst(17'h12342, 4'h0, 4); // Wraps 2, 3, 0, 1.
        rd_burst(17'h12340, 0, 3'b110);
        wr_burst(17'h12341, 4'b1010, 1);
        rd_burst(17'h12340, 1, 3'b000);
        set_order(1'b1);
        rd_burst(17'h12341, 0, 3'b011);
        wr_burst(17'h00a53, 4'h0, 4);
        rd_burst(17'h00a52, 0, 3'b110);
        adv_idle();
        sleep_cycle();
        rd_burst(17'h12342, 0, 3'b000); // Contents kept over sleep.
        close_out();
    end
endmodule
`default_nettype wire
